// File: core/sync_serial_rx_txrx.sv
// Eight-bit clocked synchronous serial port, receive and duplex modes,
// with an APB register slave.
// Assumes clk_in at 20 MHz; an external serial clock has high and low
// phases of at least four clk_in periods.
//
// Operation
// - mode 01 selects receive-only operation
// - busy rises on the first serial falling edge
// - sample input on rising edges, chosen order
// - shift-active from first to eighth falling edge
// - byte done: buffer loaded, full set, interrupt
// - internal clock starts within one serial period
// - reading receive buffer clears full flag
// - internal receive waits high until buffer read
// - byte into full buffer sets receive error
// - receive error freezes buffer and shift register
// - error reads: old byte, then captured byte
// - clearing error after read clears full flag
// - cleared start stops after current byte
// - inhibit stops at once, resets everything
// - no interrupts while receive error stands
// - mode 10 is duplex, out falling, in rising
// - duplex empty flag after load, interrupt with full
// - writing transmit buffer clears empty flag
// - internal duplex waits for write and read
// - external duplex without data sets transmit error
// - output held high on error and when stopped
// - order bit 0 MSB first, 1 LSB first
// - select 111 takes external clock pin
//
// Chosen here: the APB slave port and the placing of the registers.
`timescale 1ns/10ps

module sync_serial_rx_txrx (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic serial_clock_pin_in,
  output logic serial_clock_pin_out,
  output logic serial_clock_pin_oe_out,
  input wire logic serial_in_pin_in,
  output logic serial_out_pin_out,
  output logic port_irq_out
);

  // Byte engine phase
  typedef enum logic {ST_IDLE, ST_SHIFT} phase_t;

  // Whole state of the port
  typedef struct packed {
    phase_t st;            // Idle or shifting a byte
    logic start;           // start_bit
    logic [1:0] mode;      // transfer_mode_field
    logic order;           // bit_order_field
    logic [2:0] cksel;     // Clock select
    logic busy;            // busy_flag
    logic sact;            // shift_active_flag
    logic rx_full_flag;             // rx_full_flag
    logic rx_error_flag;           // rx_error_flag
    logic txe;             // tx_empty_flag
    logic tx_error_flag;           // tx_error_flag
    logic [7:0] rdb;       // rx_buffer
    logic [7:0] tdb;       // tx_buffer
    logic [7:0] sh_rx;     // Receive shift register
    logic [7:0] sh_tx;     // Transmit shift register
    logic [7:0] errcap;    // Shifter contents caught at an error
    logic err_rd;          // Old byte already read during an error
    logic load_pend;       // Transmit load awaiting its rising edge
    logic [2:0] cnt;       // Rising edges done in this byte
    logic sck;             // Driven serial clock level
    logic sck_oe;          // Serial clock pin driven
    logic so;              // Serial output level
    logic [7:0] div;       // Half period divider
    logic ck1;             // Clock pin synchroniser, first stage
    logic ck2;             // Second stage
    logic ck3;             // Edge detect history
    logic si1;             // Data pin synchroniser, first stage
    logic si2;             // Second stage
    logic irq;             // port_irq pulse
    logic pready;          // APB ready
    logic pslverr;         // APB error
    logic [31:0] prdata;   // APB read data
  } state_t;

  // Value after reset
  localparam state_t RST_VAL = '{
    st: ST_IDLE, sck: sio_pkg::SCK_IDLE, so: sio_pkg::SO_IDLE, ck1: sio_pkg::SCK_IDLE,
    ck2: sio_pkg::SCK_IDLE, ck3: sio_pkg::SCK_IDLE, txe: sio_pkg::TXE_RST, default: '0};

  state_t r;              // Registered state
  state_t n;              // Next state

  // Decoded events, also watched by the checks below
  logic ext_clk;          // External clock selected
  logic ok_mode;          // Receive or duplex selected
  logic duplex;           // Duplex selected
  logic go_int;           // Internal clock may start a byte
  logic fall;             // Serial clock falling edge
  logic rise;             // Serial clock rising edge
  logic byte_begin;       // First falling edge of a byte
  logic byte_done;        // Eighth rising edge of a byte
  logic inh;              // Inhibit written this cycle
  logic rd_rx;            // Receive buffer read answered this cycle
  logic tx_wr;            // Transmit buffer written this cycle
  logic err_clr;          // Receive error cleared this cycle
  logic [7:0] half_m1;    // Internal half period minus one
  logic [7:0] sh_new;     // Receive shifter after this rising edge
  logic tick;             // Divider wrap

  // Next state logic: APB first, serial engine after, so a hardware
  // set wins over a software clear in the same cycle; an inhibit, applied last, wins over both
  always_comb begin
    n = r;
    n.irq = 1'b0;
    inh = 1'b0;
    rd_rx = 1'b0;
    tx_wr = 1'b0;
    err_clr = 1'b0;

    // Pin synchronisers, two stages before any logic reads them
    n.ck1 = serial_clock_pin_in;
    n.ck2 = r.ck1;
    n.ck3 = r.ck2;
    n.si1 = serial_in_pin_in;
    n.si2 = r.si1;

    ext_clk = (r.cksel == sio_pkg::CKSEL_EXT);
    ok_mode = (r.mode == sio_pkg::MODE_RX) || (r.mode == sio_pkg::MODE_DUPLEX);
    duplex = (r.mode == sio_pkg::MODE_DUPLEX);
    half_m1 = 8'((sio_pkg::HALF_BASE << r.cksel) - 16'h0001);

    // APB slave: one wait state, then completion
    if (psel_in && penable_in && !r.pready) begin
      n.pready = 1'b1;
      n.pslverr = 1'b0;
      n.prdata = 32'h0000_0000;
      if (!pwrite_in) begin
        case (paddr_in)
          sio_pkg::CTRL_OFS: begin
            n.prdata[sio_pkg::CTRL_START_BIT] = r.start;
            n.prdata[sio_pkg::CTRL_MODE_LSB +: 2] = r.mode;
            n.prdata[sio_pkg::CTRL_ORDER_BIT] = r.order;
            n.prdata[sio_pkg::CTRL_CKSEL_LSB +: 3] = r.cksel;
          end
          sio_pkg::STAT_OFS: begin
            n.prdata[sio_pkg::STAT_BUSY_BIT] = r.busy;
            n.prdata[sio_pkg::STAT_SACT_BIT] = r.sact;
            n.prdata[sio_pkg::STAT_RXF_BIT] = r.rx_full_flag;
            n.prdata[sio_pkg::STAT_RX_ERROR_FLAG_BIT] = r.rx_error_flag;
            n.prdata[sio_pkg::STAT_TXE_BIT] = r.txe;
            n.prdata[sio_pkg::STAT_TX_ERROR_FLAG_BIT] = r.tx_error_flag;
          end
          sio_pkg::RXBUF_OFS: begin
            rd_rx = 1'b1;
            // Under an error, old byte first, then the caught shifter
            if (r.rx_error_flag && r.err_rd) begin
              n.prdata[7:0] = r.errcap;
            end else begin
              n.prdata[7:0] = r.rdb;
            end
            if (r.rx_error_flag) begin
              n.err_rd = 1'b1;
            end else begin
              n.rx_full_flag = 1'b0;
            end
          end
          sio_pkg::TXBUF_OFS: begin
            n.prdata = 32'h0000_0000; // Write only, reads zero
          end
          default: begin
            n.pslverr = 1'b1; // Unmapped address
          end
        endcase
      end else begin
        // Writes are checked here, applied at completion
        n.pslverr = !((paddr_in == sio_pkg::CTRL_OFS) || (paddr_in == sio_pkg::STAT_OFS)
          || (paddr_in == sio_pkg::RXBUF_OFS) || (paddr_in == sio_pkg::TXBUF_OFS));
      end
    end else if (psel_in && penable_in && r.pready) begin
      n.pready = 1'b0;
      if (pwrite_in) begin
        case (paddr_in)
          sio_pkg::CTRL_OFS: begin
            n.start = pwdata_in[sio_pkg::CTRL_START_BIT];
            n.mode = pwdata_in[sio_pkg::CTRL_MODE_LSB +: 2];
            n.order = pwdata_in[sio_pkg::CTRL_ORDER_BIT];
            n.cksel = pwdata_in[sio_pkg::CTRL_CKSEL_LSB +: 3];
            inh = pwdata_in[sio_pkg::CTRL_INH_BIT];
          end
          sio_pkg::STAT_OFS: begin
            if (pwdata_in[sio_pkg::STAT_RX_ERROR_FLAG_BIT]) begin
              err_clr = 1'b1;
              n.rx_error_flag = 1'b0;
              n.err_rd = 1'b0;
              // Full flag goes only once the data has been read
              if (r.err_rd) begin
                n.rx_full_flag = 1'b0;
              end
            end
          end
          sio_pkg::TXBUF_OFS: begin
            tx_wr = 1'b1;
            n.tdb = pwdata_in[7:0];
            n.txe = 1'b0;
          end
          default: begin
            n.tdb = r.tdb; // Receive buffer and holes ignore writes
          end
        endcase
      end
    end else begin
      n.pready = 1'b0;
      n.pslverr = 1'b0;
    end
    // Internal clock may run when nothing blocks the next byte
    go_int = !ext_clk && ok_mode && r.start && !r.rx_full_flag && !r.rx_error_flag
      && (!duplex || !r.txe);
    // Internal serial clock generator, parked high between bytes
    n.sck_oe = !ext_clk;
    tick = (r.div == half_m1);
    if (!ext_clk && (r.st == ST_SHIFT || go_int)) begin
      n.div = tick ? 8'h00 : 8'(r.div + 8'h01);
      if (tick) begin
        n.sck = !r.sck;
      end
    end else begin
      n.div = 8'h00;
      n.sck = sio_pkg::SCK_IDLE;
    end
    // Edges from whichever clock is selected
    if (ext_clk) begin
      fall = r.ck3 && !r.ck2;
      rise = !r.ck3 && r.ck2;
    end else begin
      fall = tick && r.sck && (r.st == ST_SHIFT || go_int);
      rise = tick && !r.sck && (r.st == ST_SHIFT);
    end
    byte_begin = fall && (r.st == ST_IDLE) && r.start && ok_mode;
    byte_done = rise && (r.st == ST_SHIFT) && (r.cnt == sio_pkg::LAST_BIT);
    // Received bit enters at the end chosen by the order field
    if (r.order) begin
      sh_new = {r.si2, r.sh_rx[7:1]};
    end else begin
      sh_new = {r.sh_rx[6:0], r.si2};
    end
    // A stopped port with no byte running is not busy
    if (r.st == ST_IDLE && !r.start) begin
      n.busy = 1'b0;
      n.so = sio_pkg::SO_IDLE;
    end
    case (r.st)
      ST_IDLE: begin
        if (byte_begin) begin
          n.st = ST_SHIFT;
          n.busy = 1'b1;
          n.sact = 1'b1;
          n.cnt = 3'h0;
          if (duplex && !r.txe) begin
            n.sh_tx = r.tdb;
            n.load_pend = 1'b1;
            n.so = r.order ? r.tdb[0] : r.tdb[7];
          end else begin
            n.so = sio_pkg::SO_IDLE;
            if (duplex) begin
              n.tx_error_flag = 1'b1;
            end
          end
        end
      end
      ST_SHIFT: begin
        if (fall) begin
          if (duplex && !r.tx_error_flag) begin
            n.so = r.order ? r.sh_tx[r.cnt] : r.sh_tx[3'(sio_pkg::LAST_BIT - r.cnt)];
          end else begin
            n.so = sio_pkg::SO_IDLE;
          end
          if (r.cnt == sio_pkg::LAST_BIT) begin
            n.sact = 1'b0;
          end
        end
        if (rise) begin
          if (r.load_pend) begin
            n.txe = 1'b1;
            n.load_pend = 1'b0;
          end
          if (!r.rx_error_flag) begin
            n.sh_rx = sh_new;
          end
          n.cnt = 3'(r.cnt + 3'h1);
          if (byte_done) begin
            n.st = ST_IDLE;
            n.cnt = 3'h0;
            if (!r.start) begin
              n.busy = 1'b0;
            end
            if (r.rx_error_flag) begin
              n.irq = 1'b0;
            end else if (r.rx_full_flag) begin
              n.rx_error_flag = 1'b1;
              n.errcap = sh_new;
              n.irq = 1'b1;
            end else begin
              n.rdb = sh_new;
              n.rx_full_flag = 1'b1;
              n.irq = 1'b1;
            end
          end
        end
      end
      default: begin
        n.st = ST_IDLE;
      end
    endcase

    // Inhibit stops at once and returns everything to rest
    if (inh) begin
      n.st = ST_IDLE;
      n.start = 1'b0;
      n.busy = 1'b0;
      n.sact = 1'b0;
      n.rx_full_flag = 1'b0;
      n.rx_error_flag = 1'b0;
      n.txe = sio_pkg::TXE_RST;
      n.tx_error_flag = 1'b0;
      n.rdb = sio_pkg::BUF_RST;
      n.tdb = sio_pkg::BUF_RST;
      n.sh_rx = sio_pkg::BUF_RST;
      n.sh_tx = sio_pkg::BUF_RST;
      n.errcap = sio_pkg::BUF_RST;
      n.err_rd = 1'b0;
      n.load_pend = 1'b0;
      n.cnt = 3'h0;
      n.sck = sio_pkg::SCK_IDLE;
      n.div = 8'h00;
      n.so = sio_pkg::SO_IDLE;
      n.irq = 1'b0;
    end
  end

  // State register, synchronous active-low reset
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      r <= RST_VAL;
    end else begin
      r <= n;
    end
  end

  // All outputs straight from flip-flops
  assign prdata_out = r.prdata;
  assign pready_out = r.pready;
  assign pslverr_out = r.pslverr;
  assign serial_clock_pin_out = r.sck;
  assign serial_clock_pin_oe_out = r.sck_oe;
  assign serial_out_pin_out = r.so;
  assign port_irq_out = r.irq;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  // A byte that lands on a full buffer
  sequence s_err_byte;
    byte_done && r.rx_full_flag && !r.rx_error_flag && !inh;
  endsequence
  // A clean byte completion
  sequence s_good_byte;
    byte_done && !r.rx_full_flag && !r.rx_error_flag && !inh;
  endsequence
  a_busy_on_fall: assert property (byte_begin && !inh |=> r.busy && r.sact)
    else $error("busy or shift-active not set at first falling edge");
  a_sact_end: assert property ((r.st == ST_SHIFT) && fall && (r.cnt == 3'h7) |=> !r.sact)
    else $error("shift-active still high after eighth falling edge");
  a_rx_complete: assert property (s_good_byte |=> r.rx_full_flag && r.irq && (r.rdb == $past(sh_new)))
    else $error("completed byte not delivered to receive buffer");
  a_read_clear: assert property (rd_rx && !r.rx_error_flag && !byte_done && !inh |=> !r.rx_full_flag)
    else $error("receive buffer read left full flag set");
  a_err_set: assert property (s_err_byte |=> r.rx_error_flag && r.irq && $stable(r.rdb))
    else $error("overrun did not raise receive error");
  a_err_freeze: assert property (r.rx_error_flag && !err_clr && !inh |=> $stable(r.rdb) && $stable(r.sh_rx))
    else $error("data changed during receive error");
  a_err_second: assert property (rd_rx && r.rx_error_flag && r.err_rd |=> r.prdata[7:0] == r.errcap)
    else $error("second error read did not return caught shifter");
  a_err_no_irq: assert property (r.rx_error_flag |=> !r.irq)
    else $error("interrupt raised while receive error stands");
  a_inhibit_all: assert property (inh |=> !r.start && !r.busy && !r.rx_full_flag && !r.tx_error_flag
    && (r.rdb == 8'h00) && (r.st == ST_IDLE))
    else $error("inhibit did not reset the port");
  a_park_high: assert property (!ext_clk && (r.st == ST_IDLE) && r.rx_full_flag |=> r.sck)
    else $error("internal clock not parked high while buffer full");
  a_tx_write: assert property (tx_wr && !(rise && r.load_pend) |=> !r.txe)
    else $error("transmit write did not clear empty flag");
endmodule

// File: core/sio_pkg.sv
// Constants for the eight-bit synchronous serial port: APB map, field
// positions, mode codes, reset values and clock divider settings.
// Assumes a 32-bit APB bus and one aligned word per register.
package sio_pkg;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;   // serial_ctrl_reg
  localparam logic [7:0] STAT_OFS = 8'h04;   // serial_status_reg
  localparam logic [7:0] RXBUF_OFS = 8'h08;  // rx_buffer, read only
  localparam logic [7:0] TXBUF_OFS = 8'h0C;  // tx_buffer, write only

  // Control register fields
  localparam int CTRL_START_BIT = 0;   // start_bit
  localparam int CTRL_INH_BIT = 1;     // inhibit_bit, self clearing
  localparam int CTRL_MODE_LSB = 2;    // transfer_mode_field, two bits
  localparam int CTRL_ORDER_BIT = 4;   // bit_order_field
  localparam int CTRL_CKSEL_LSB = 5;   // clock select, three bits

  // Status register fields
  localparam int STAT_BUSY_BIT = 0;    // busy_flag
  localparam int STAT_SACT_BIT = 1;    // shift_active_flag
  localparam int STAT_RXF_BIT = 2;     // rx_full_flag
  localparam int STAT_RX_ERROR_FLAG_BIT = 3;   // rx_error_flag, write 1 clears
  localparam int STAT_TXE_BIT = 4;     // tx_empty_flag
  localparam int STAT_TX_ERROR_FLAG_BIT = 5;   // tx_error_flag

  // Transfer mode codes
  localparam logic [1:0] MODE_TX = 2'h0;
  localparam logic [1:0] MODE_RX = 2'h1;
  localparam logic [1:0] MODE_DUPLEX = 2'h2;

  // Clock select code for the external clock pin
  localparam logic [2:0] CKSEL_EXT = 3'h7;

  // Internal half period is HALF_BASE shifted left by the select code
  localparam logic [15:0] HALF_BASE = 16'h0002;

  // Bits per byte, last bit index of the counter
  localparam logic [2:0] LAST_BIT = 3'h7;

  // Values after reset or inhibit
  localparam logic SCK_IDLE = 1'b1;
  localparam logic SO_IDLE = 1'b1;
  localparam logic TXE_RST = 1'b1;
  localparam logic [7:0] BUF_RST = 8'h00;

endpackage

// File: bench/serial_peer.sv
// Behavioural model of the external synchronous serial peer.
// Assumes the bench resolves the shared clock wire and calls load before each byte.
`timescale 1ns/10ps

module serial_peer (
  input wire logic sck_in,
  input wire logic so_in,
  input wire logic lsb_first_in,
  output logic sck_drive_out,
  output logic si_out
);
  logic [7:0] tx_q; // Byte to send
  logic [7:0] rx_q; // Byte caught from the device
  logic [3:0] fall_n; // Falling edges in this byte
  logic [3:0] rise_n; // Rising edges in this byte

  // Idle levels before any frame
  initial begin
    sck_drive_out = 1'b1;
    si_out = 1'b1;
    tx_q = 8'h00;
    rx_q = 8'h00;
    fall_n = 4'h0;
    rise_n = 4'h0;
  end

  // Arm a new byte; counters restart at each byte boundary
  task automatic load(input logic [7:0] b);
    tx_q = b;
    fall_n = 4'h0;
    rise_n = 4'h0;
  endtask

  // One byte of external clock, standing high between frames
  task automatic xfer();
    #13;
    repeat (8) begin
      sck_drive_out = 1'b0;
      #200;
      sck_drive_out = 1'b1;
      #200;
    end
  endtask

  // Next bit goes out on each falling edge
  always @(negedge sck_in) begin
    si_out <= lsb_first_in ? tx_q[fall_n[2:0]] : tx_q[3'h7 - fall_n[2:0]];
    fall_n <= fall_n + 4'h1;
  end

  // Sample 60 ns into the high phase, since the device output lags the edge
  always @(posedge sck_in) begin
    #60;
    rx_q = lsb_first_in ? {so_in, rx_q[7:1]} : {rx_q[6:0], so_in};
    rise_n = rise_n + 4'h1;
    if (rise_n == 4'h8) begin
      #90;
      si_out = ~si_out; // Released line must not look like valid data
    end
  end
endmodule

// File: bench/sync_serial_rx_txrx_tb.sv
// Self-checking bench: APB tasks run receive, duplex, error and inhibit
// sequences against the peer model.
// Assumes the design package, design and peer model are compiled first.
`timescale 1ns/10ps

module sync_serial_rx_txrx_tb;
  localparam logic [7:0] A_CTRL = sio_pkg::CTRL_OFS;
  localparam logic [7:0] A_STAT = sio_pkg::STAT_OFS;
  localparam logic [7:0] A_RX = sio_pkg::RXBUF_OFS;
  localparam logic [7:0] A_TX = sio_pkg::TXBUF_OFS;
  localparam logic [31:0] S_BUSY = 32'h1 << sio_pkg::STAT_BUSY_BIT;
  localparam logic [31:0] S_RXF = 32'h1 << sio_pkg::STAT_RXF_BIT;
  localparam logic [31:0] S_RXE = 32'h1 << sio_pkg::STAT_RX_ERROR_FLAG_BIT;
  localparam logic [31:0] S_TXE = 32'h1 << sio_pkg::STAT_TXE_BIT;
  localparam logic [31:0] S_TXR = 32'h1 << sio_pkg::STAT_TX_ERROR_FLAG_BIT;
  localparam logic [31:0] ALL = 32'hFFFFFFFF;

  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic sck_out;
  logic sck_oe;
  logic peer_sck;
  logic si;
  logic so;
  logic irq;
  logic order = 1'b0; // Bit order the peer follows
  wire sck_w = sck_oe ? sck_out : peer_sck; // Shared clock wire
  int bad_count = 0;
  int samples_checked = 0;
  int irq_n = 0; // Interrupt pulses seen
  logic [31:0] q;
  logic e;

  // 20 MHz system clock
  always #25 clk_in = ~clk_in;

  // Count one-cycle interrupt pulses
  always @(posedge clk_in) begin
    if (irq === 1'b1) begin
      irq_n <= irq_n + 1;
    end
  end

  sync_serial_rx_txrx u_sync_serial_rx_txrx (
    .clk_in(clk_in), .nrst_in(nrst_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .serial_clock_pin_in(sck_w),
    .serial_clock_pin_out(sck_out), .serial_clock_pin_oe_out(sck_oe),
    .serial_in_pin_in(si), .serial_out_pin_out(so), .port_irq_out(irq)
  );

  serial_peer u_serial_peer (
    .sck_in(sck_w), .so_in(so), .lsb_first_in(order),
    .sck_drive_out(peer_sck), .si_out(si)
  );

  // Verdict and end of run
  task automatic stop_test();
    if (bad_count == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Compare one value
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Compare one pin level
  task automatic chk1(input logic got, input logic exp);
    chk32({31'h0, got}, {31'h0, exp});
  endtask

  // APB transfer; held until pready is seen, idle edge after release
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      bad_count++;
      stop_test();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk32(q & m, x);
  endtask

  function automatic logic [31:0] ctrl(input logic st, input logic [1:0] m, input logic o,
                                       input logic [2:0] s);
    ctrl = 32'h0;
    ctrl[sio_pkg::CTRL_START_BIT] = st;
    ctrl[sio_pkg::CTRL_MODE_LSB +: 2] = m;
    ctrl[sio_pkg::CTRL_ORDER_BIT] = o;
    ctrl[sio_pkg::CTRL_CKSEL_LSB +: 3] = s;
  endfunction

  // Bounded wait for the interrupt count to reach a target
  task automatic wait_irq(input int target);
    int n;
    n = 0;
    while (irq_n < target && n < 4000) begin
      @(posedge clk_in);
      n++;
    end
    if (irq_n < target) begin
      bad_count++;
      stop_test();
    end
    @(posedge clk_in);
  endtask

  // Immediate stop, everything back to initial values
  task automatic inhibit();
    apb(1'b1, A_CTRL, 32'h1 << sio_pkg::CTRL_INH_BIT);
    rd_chk(A_CTRL, ALL, 32'h0);
    rd_chk(A_STAT, ALL, S_TXE);
    rd_chk(A_RX, ALL, 32'h0);
  endtask

  // One externally clocked byte from the peer
  task automatic ext(input logic [7:0] b);
    u_serial_peer.load(b);
    u_serial_peer.xfer();
    repeat (8) @(posedge clk_in);
  endtask

  initial begin
    repeat (6) @(posedge clk_in);
    nrst_in <= 1'b1;
    @(posedge clk_in);
    // Reset state and an unmapped address
    rd_chk(A_CTRL, ALL, 32'h0);
    rd_chk(A_STAT, ALL, S_TXE);
    rd_chk(8'h10, ALL, 32'h0);
    chk1(e, 1'b1);
    chk1(sck_out, sio_pkg::SCK_IDLE);
    chk1(so, sio_pkg::SO_IDLE);
    // Internal clock receive, MSB first, auto wait
    u_serial_peer.load(8'hA5);
    apb(1'b1, A_CTRL, ctrl(1'b1, sio_pkg::MODE_RX, 1'b0, 3'h1));
    wait_irq(1);
    rd_chk(A_STAT, S_RXF, S_RXF);
    repeat (40) @(posedge clk_in);
    chk1(sck_out, 1'b1);
    chk32(32'(irq_n), 32'h1);
    u_serial_peer.load(8'h3C);
    rd_chk(A_RX, ALL, 32'hA5);
    rd_chk(A_STAT, S_RXF, 32'h0);
    wait_irq(2);
    apb(1'b1, A_CTRL, ctrl(1'b0, sio_pkg::MODE_RX, 1'b0, 3'h1));
    rd_chk(A_RX, ALL, 32'h3C);
    repeat (100) @(posedge clk_in);
    rd_chk(A_STAT, S_BUSY | S_RXF, 32'h0);
    chk32(32'(irq_n), 32'h2);
    // Internal clock duplex, LSB first
    inhibit();
    order = 1'b1;
    apb(1'b1, A_TX, 32'h96);
    rd_chk(A_STAT, S_TXE, 32'h0);
    u_serial_peer.load(8'h4B);
    apb(1'b1, A_CTRL, ctrl(1'b1, sio_pkg::MODE_DUPLEX, 1'b1, 3'h1));
    wait_irq(3);
    rd_chk(A_STAT, S_TXE | S_RXF, S_TXE | S_RXF);
    chk32({24'h0, u_serial_peer.rx_q}, 32'h96);
    u_serial_peer.load(8'hC3);
    rd_chk(A_RX, ALL, 32'h4B);
    repeat (60) @(posedge clk_in);
    chk1(sck_out, 1'b1);
    chk32(32'(irq_n), 32'h3);
    apb(1'b1, A_TX, 32'h5A);
    wait_irq(4);
    rd_chk(A_RX, ALL, 32'hC3);
    chk32({24'h0, u_serial_peer.rx_q}, 32'h5A);
    // External clock receive with overrun
    inhibit();
    order = 1'b0;
    apb(1'b1, A_CTRL, ctrl(1'b1, sio_pkg::MODE_RX, 1'b0, sio_pkg::CKSEL_EXT));
    repeat (2) @(posedge clk_in);
    chk1(sck_oe, 1'b0);
    ext(8'h11);
    chk32(32'(irq_n), 32'h5);
    ext(8'h22);
    rd_chk(A_STAT, S_RXF | S_RXE, S_RXF | S_RXE);
    chk32(32'(irq_n), 32'h6);
    ext(8'h33);
    chk32(32'(irq_n), 32'h6);
    apb(1'b1, A_CTRL, ctrl(1'b0, sio_pkg::MODE_RX, 1'b0, sio_pkg::CKSEL_EXT));
    rd_chk(A_RX, ALL, 32'h11);
    rd_chk(A_RX, ALL, 32'h22);
    apb(1'b1, A_STAT, S_RXE);
    rd_chk(A_STAT, S_RXF | S_RXE | S_BUSY, 32'h0);
    // External clock duplex, then a missing transmit byte
    inhibit();
    apb(1'b1, A_TX, 32'hE0);
    apb(1'b1, A_CTRL, ctrl(1'b1, sio_pkg::MODE_DUPLEX, 1'b0, sio_pkg::CKSEL_EXT));
    ext(8'h77);
    chk32({24'h0, u_serial_peer.rx_q}, 32'hE0);
    rd_chk(A_RX, ALL, 32'h77);
    ext(8'h88);
    rd_chk(A_STAT, S_TXR, S_TXR);
    chk32(32'(irq_n), 32'h8);
    chk32({24'h0, u_serial_peer.rx_q}, 32'hFF);
    chk1(so, 1'b1);
    rd_chk(A_RX, ALL, 32'h88);
    inhibit();
    stop_test();
  end
endmodule
